// [rpt_bank.sv]
// One bank's row timer: tRAS, tRTP, auto precharge launch and tRP
`timescale 1ns/1ps
module rpt_bank
  import rpt_pkg::*;
#(
  parameter int AL = 1,
  parameter int BL = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic act,
  input  wire logic rd,
  input  wire logic ap,
  input  wire logic pre,
  output logic      busy_q,
  output logic      ap_start_q
);
  initial begin
    if (!(BL == 4 || BL == 8) || AL < 0 || AL > 6) $error("rpt_bank: bad AL/BL");
  end
  localparam logic [RPT_CNT_W-1:0] AP_EDGE = RPT_CNT_W'(AL + BL / 2);
  // Last prefetch begins at AL (BL4) or AL+2 (BL8)
  localparam logic [RPT_CNT_W-1:0] PREF_END = RPT_CNT_W'(AL + BL / 2 - 2 + RPT_PREF_GAP);
  localparam logic [RPT_CNT_W-1:0] RTP_END =
    RPT_CNT_W'(AL + BL / 2 - 2 + RPT_TRTP_CK);
  localparam logic [RPT_CNT_W-1:0] RAS_END = RPT_CNT_W'(RPT_TRAS_CK);
  localparam logic [RPT_CNT_W-1:0] RP_END  = RPT_CNT_W'(RPT_TRP_CK);
  localparam logic [RPT_CNT_W-1:0] CMAX    = {RPT_CNT_W{1'b1}};

  rpt_state_t st_q;
  logic [RPT_CNT_W-1:0] ras_q, rd_q, rp_q;
  logic ok;

  function automatic logic [RPT_CNT_W-1:0] inc(input logic [RPT_CNT_W-1:0] v);
    return (v == CMAX) ? v : v + 1'b1;
  endfunction

  // Launch only when every minimum holds; checked each cycle, so late ones defer it
  assign ok = rd_q >= AP_EDGE && rd_q >= PREF_END && rd_q >= RTP_END
              && ras_q >= RAS_END;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= RPT_IDLE;
    end else begin
      case (st_q)
        RPT_IDLE:    if (act) st_q <= RPT_OPEN;
        RPT_OPEN: begin
          if (pre) st_q <= RPT_PRECH;
          else if (rd && ap) st_q <= RPT_AP_WAIT;
        end
        RPT_AP_WAIT: if (ok) st_q <= RPT_PRECH;
        RPT_PRECH:   if (rp_q + 1'b1 >= RP_END) st_q <= RPT_IDLE;
        default:     st_q <= RPT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) ras_q <= RPT_CNT_RST;
    else if (act && st_q == RPT_IDLE) ras_q <= 6'h01;
    else ras_q <= inc(ras_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) rd_q <= RPT_CNT_RST;
    else if (rd && st_q == RPT_OPEN) rd_q <= 6'h01;
    else rd_q <= inc(rd_q);
  end

  // tRP counts from the launch itself, not from a later edge
  always_ff @(posedge clk) begin
    if (!rst_n) rp_q <= RPT_CNT_RST;
    else if (st_q != RPT_PRECH) rp_q <= RPT_CNT_RST;
    else rp_q <= inc(rp_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      ap_start_q <= 1'b0;
    end else begin
      busy_q     <= (st_q == RPT_AP_WAIT) || (st_q == RPT_PRECH);
      ap_start_q <= (st_q == RPT_AP_WAIT) && ok;
    end
  end

  sequence ap_cmd_s;
    st_q == RPT_OPEN && rd && ap;
  endsequence

  ap_not_early_a: assert property (@(posedge clk) disable iff (!rst_n)
    ap_cmd_s |-> !(st_q == RPT_PRECH) [*1] ##1 (st_q != RPT_PRECH) [*2])
    else $error("auto precharge launched too early");
  ap_ras_met_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_q) == RPT_AP_WAIT && st_q == RPT_PRECH) |-> $past(ras_q) >= RAS_END)
    else $error("auto precharge before tRAS");
  ap_rtp_met_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_q) == RPT_AP_WAIT && st_q == RPT_PRECH) |->
      $past(rd_q) >= AP_EDGE && $past(rd_q) >= RTP_END)
    else $error("auto precharge before read edge or tRTP");
  ap_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_q) == RPT_AP_WAIT && st_q == RPT_PRECH) |-> ap_start_q)
    else $error("launch pulse missing");
  rp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_q) == RPT_PRECH && st_q != RPT_PRECH) |-> $past(rp_q) + 1 >= RP_END)
    else $error("precharge shorter than tRP");
endmodule

// [rpt_pkg.sv]
// Package: timing constants, command types and per-bank state for the read-precharge block
package rpt_pkg;
  localparam int RPT_BANKS     = 8;
  localparam int RPT_CLK_MHZ   = 25;
  localparam int RPT_CLK_PS    = 40000;
  localparam int RPT_TRAS_PS   = 40000;
  localparam int RPT_TRTP_PS   = 7500;
  localparam int RPT_TRP_PS    = 15000;
  // Analog times round up to whole clocks
  localparam int RPT_TRAS_CK   = (RPT_TRAS_PS + RPT_CLK_PS - 1) / RPT_CLK_PS;
  localparam int RPT_TRTP_CK   = (RPT_TRTP_PS + RPT_CLK_PS - 1) / RPT_CLK_PS;
  localparam int RPT_TRP_CK    = (RPT_TRP_PS + RPT_CLK_PS - 1) / RPT_CLK_PS;
  localparam int RPT_PREF_GAP  = 2;
  localparam int RPT_AP_BIT    = 10;
  localparam int RPT_CNT_W     = 6;
  localparam logic [RPT_CNT_W-1:0] RPT_CNT_RST = 6'h00;

  typedef enum logic [2:0] {
    RPT_CMD_NOP, RPT_CMD_ACT, RPT_CMD_RD, RPT_CMD_WR, RPT_CMD_PRE
  } rpt_cmd_t;

  typedef struct packed {
    rpt_cmd_t    cmd;
    logic [2:0]  bank;
    logic [13:0] addr;
  } rpt_req_t;

  typedef enum logic [1:0] {
    RPT_IDLE, RPT_OPEN, RPT_AP_WAIT, RPT_PRECH
  } rpt_state_t;
endpackage

// [rpt_top.sv]
// Eight-bank read/auto-precharge timing core for the device side
`timescale 1ns/1ps
module rpt_top
  import rpt_pkg::*;
#(
  parameter int AL = 1,
  parameter int BL = 4
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESETN,
  input  wire rpt_req_t             REQ,
  output logic [RPT_BANKS-1:0]      BANK_BUSY,
  output logic [RPT_BANKS-1:0]      AP_START
);
  logic [RPT_BANKS-1:0] busy_w, ap_w;
  logic                 ap_flag;

  // Commands come from same-clock controller logic, so no synchroniser
  assign ap_flag = REQ.addr[RPT_AP_BIT];

  for (genvar b = 0; b < RPT_BANKS; b++) begin : g_bank
    rpt_bank #(
      .AL (AL),
      .BL (BL)
    ) u_bank (
      .clk        (CLK_SYS),
      .rst_n      (RESETN),
      .act        (REQ.cmd == RPT_CMD_ACT && REQ.bank == 3'(b)),
      .rd         (REQ.cmd == RPT_CMD_RD && REQ.bank == 3'(b)),
      .ap         (ap_flag),
      .pre        (REQ.cmd == RPT_CMD_PRE && REQ.bank == 3'(b)),
      .busy_q     (busy_w[b]),
      .ap_start_q (ap_w[b])
    );
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      BANK_BUSY <= '0;
      AP_START  <= '0;
    end else begin
      BANK_BUSY <= busy_w;
      AP_START  <= ap_w;
    end
  end

  busy_after_ap_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (REQ.cmd == RPT_CMD_RD && ap_flag && !busy_w[REQ.bank]) |-> ##3 BANK_BUSY != '0)
    else $error("auto precharge read did not mark bank busy");
  start_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    AP_START != '0 |-> $past(busy_w) != '0)
    else $error("launch without busy bank");
endmodule

// [rpt_ctl_model.sv]
// Controller model that spaces commands to the read-precharge block
`timescale 1ns/1ps
module rpt_ctl_model
  import rpt_pkg::*;
#(
  parameter int AL = 1,
  parameter int BL = 4
) (
  input  wire logic clk,
  output rpt_req_t  req
);
  localparam int RTP2 = (RPT_TRTP_CK > 2) ? RPT_TRTP_CK : 2;
  localparam int ACT_GAP = AL + RPT_TRTP_CK + RPT_TRP_CK + ((BL == 8) ? 2 : 0);
  int cyc = 0;
  int rd_at [RPT_BANKS];
  bit ap_at [RPT_BANKS];
  initial begin
    req = '{cmd: RPT_CMD_NOP, bank: 3'h0, addr: 14'h0000};
    foreach (rd_at[i]) rd_at[i] = -999;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Stamps per bank keep each bank's spacing apart
  task automatic issue(input rpt_cmd_t cmd, input int b, input bit a10);
    int gap;
    gap = 0;
    if (cmd == RPT_CMD_PRE && ap_at[b]) return;
    if (cmd == RPT_CMD_WR) gap = AL + BL / 2;
    if (cmd == RPT_CMD_PRE) gap = AL + BL / 2 + RTP2 - 2;
    if (cmd == RPT_CMD_ACT && ap_at[b]) gap = ACT_GAP;
    while (cyc - rd_at[b] < gap) @(posedge clk);
    req <= '{cmd: cmd, bank: b[2:0], addr: {3'h0, a10, 10'h000}};
    if (cmd == RPT_CMD_RD) rd_at[b] = cyc;
    if (cmd == RPT_CMD_RD) ap_at[b] = a10;
    if (cmd == RPT_CMD_ACT) ap_at[b] = 1'b0;
    @(posedge clk);
    req.cmd <= RPT_CMD_NOP;
    // Extra edge so the next command never lands in the same step as the release
    @(posedge clk);
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the read-precharge timing core
`timescale 1ns/1ps
module tb;
  import rpt_pkg::*;
  localparam int AL = 1;
  localparam int BL = 4;
  logic                 clk_sys = 1'b0;
  logic                 resetn  = 1'b0;
  rpt_req_t             req;
  logic [RPT_BANKS-1:0] bank_busy;
  logic [RPT_BANKS-1:0] ap_start;
  int                   n_errors = 0;
  int                   total_checks = 0;
  int                   ticks = 0;
  always #20 clk_sys = ~clk_sys;
  rpt_top #(.AL(AL), .BL(BL)) rpt_top_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .REQ(req),
    .BANK_BUSY(bank_busy), .AP_START(ap_start));
  rpt_ctl_model #(.AL(AL), .BL(BL)) rpt_ctl_model_inst (.clk(clk_sys), .req(req));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_auto(input int b);
    int n;
    @(posedge clk_sys);
    rpt_ctl_model_inst.issue(RPT_CMD_ACT, b, 1'b0);
    rpt_ctl_model_inst.issue(RPT_CMD_RD, b, 1'b1);
    n = 0;
    #1;
    while (ap_start[b] !== 1'b1 && n < 30) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // Launch AL+BL/2 after the read, two flops to the pin, and issue returns and the
    // first look come one edge each after the read is taken
    check(16'(n), 16'(AL + BL / 2 + 2 - 2));
    check({bank_busy[b], 7'h00, ap_start}, {1'b1, 7'h00, 8'h01 << b});
    @(posedge clk_sys);
    #1;
    check({8'h00, ap_start}, 16'h0000);
    n = 0;
    while (bank_busy[b] !== 1'b0 && n < 30) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({8'h00, bank_busy}, 16'h0000);
    $display("done auto precharge bank %0d", b);
  endtask
  task automatic t_plain(input int b);
    logic [7:0] seen;
    seen = 8'h00;
    @(posedge clk_sys);
    rpt_ctl_model_inst.issue(RPT_CMD_ACT, b, 1'b0);
    rpt_ctl_model_inst.issue(RPT_CMD_RD, b, 1'b0);
    rpt_ctl_model_inst.issue(RPT_CMD_WR, b, 1'b0);
    rpt_ctl_model_inst.issue(RPT_CMD_PRE, b, 1'b0);
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      seen = seen | ap_start;
    end
    check({8'h00, seen}, 16'h0000);
    $display("done plain read bank %0d", b);
  endtask
  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check({bank_busy, ap_start}, 16'h0000);
    for (int b = 0; b < RPT_BANKS; b++) t_auto(b);
    t_plain(3);
    t_auto(3);
    report_and_stop();
  end
endmodule
